// ---- include/sfc_defs.svh ----
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH
// Register byte offsets on the AXI4-Lite slave
`define SFC_A_CMD   8'h00
`define SFC_A_ICR   8'h04
`define SFC_A_RCR   8'h08
`define SFC_A_MODE  8'h0C
`define SFC_A_TCR   8'h10
`define SFC_A_SADR  8'h14
`define SFC_A_FLAG  8'h18
`define SFC_A_TXD   8'h1C
`define SFC_A_RXD   8'h20
`define SFC_A_ST0   8'h24
`define SFC_A_ST1   8'h28
`define SFC_A_VEC   8'h2C
// Channel commands, command register bits 5:3
`define SFC_CMD_ABORT  3'h1
`define SFC_CMD_RSTEXT 3'h2
`define SFC_CMD_CHRST  3'h3
`define SFC_CMD_NEXTRX 3'h4
`define SFC_CMD_RSTTX  3'h5
`define SFC_CMD_ERRRST 3'h6
// CRC reset codes, command register bits 7:6
`define SFC_CRC_TXPRE  2'h2
`define SFC_CRC_EOMCLR 2'h3
// Receive interrupt modes
`define SFC_RXI_OFF   2'h0
`define SFC_RXI_FIRST 2'h1
`define SFC_RXI_EVERY 2'h2
// Character length codes to bit counts
`define SFC_BITS_C0 4'h5
`define SFC_BITS_C1 4'h7
`define SFC_BITS_C2 4'h6
`define SFC_BITS_C3 4'h8
// Framing constants
`define SFC_FLAG_RST  8'h7E
`define SFC_GLOBAL    8'hFF
`define SFC_STUFF     4'h5
`define SFC_ABORT_RX  4'h7
`define SFC_ABORT_TX  5'h08
`define SFC_ONES_MAX  4'hF
`define SFC_DLY       4'h7
`define SFC_CHAR8     4'h8
`define SFC_CRC_LEN   5'h10
`define SFC_FLAG_LEN  5'h08
`define SFC_CRC_ONES  16'hFFFF
`define SFC_CRC_POLY  16'h1021
`define SFC_CRC_GOOD  16'h1D0F
// Vector cause codes
`define SFC_V_NONE 3'h0
`define SFC_V_TX   3'h1
`define SFC_V_EXT  3'h2
`define SFC_V_RX   3'h3
`define SFC_V_SPEC 3'h4
// AXI responses
`define SFC_OKAY   2'h0
`define SFC_SLVERR 2'h2
`endif

// ---- include/sfc_pkg.sv ----
package sfc_pkg;
  typedef struct packed {
    logic       awvalid;
    logic [7:0] awaddr;
    logic       wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic       bready;
    logic       arvalid;
    logic [7:0] araddr;
    logic       rready;
  } sfc_axi_in_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sfc_axi_out_t;
  typedef struct packed {
    logic [1:0] crc; logic [2:0] cmd; logic [2:0] ptr;
  } sfc_cmd_t;
  typedef struct packed {
    logic [2:0] rsv; logic [1:0] rx_mode; logic sav; logic tx_ie; logic ext_ie;
  } sfc_icr_t;
  typedef struct packed {
    logic [1:0] len; logic auto_en; logic hunt; logic crc_en; logic adr_srch;
    logic rsv; logic rx_en;
  } sfc_rcr_t;
  typedef struct packed {
    logic dtr; logic [1:0] len; logic rsv; logic tx_en; logic crc_sel;
    logic rts; logic crc_en;
  } sfc_tcr_t;
  typedef struct packed {
    logic brk; logic eom; logic cts; logic hunt; logic rsv; logic tbe;
    logic ip; logic rca;
  } sfc_st0_t;
  typedef struct packed {
    logic eof; logic crc_err; logic ovr; logic rsv; logic [2:0] res; logic sent;
  } sfc_st1_t;
  typedef enum logic [1:0] {RX_HUNT, RX_WAIT, RX_OPEN, RX_DATA} sfc_rx_e;
  typedef enum logic [2:0] {TX_MARK, TX_FLAG, TX_DATA, TX_CRC, TX_ABORT} sfc_tx_e;
  typedef struct packed {
    logic aw_got; logic [7:0] awa; logic w_got; logic [7:0] wd; logic wst;
    logic awrdy; logic wrdy; logic bvld; logic [1:0] bresp;
    logic arrdy; logic rvld; logic [7:0] rdata; logic [1:0] rresp;
  } sfc_bus_t;
  typedef struct packed {
    sfc_bus_t bus;
    logic [1:0] l_clk; logic [1:0] l_rx; logic [1:0] l_cts; logic lclk_q;
    sfc_icr_t icr; sfc_rcr_t rcr; logic [7:0] mode; sfc_tcr_t tcr;
    logic [7:0] sadr; logic [7:0] flag;
    sfc_rx_e rs; logic [7:0] win; logic [3:0] ones; logic [6:0] dly; logic [3:0] dn;
    logic [7:0] asm; logic [3:0] an; logic first; logic [15:0] crc;
    logic [7:0] rbuf; logic rca; logic ovr; logic eof; logic crcerr; logic [2:0] res;
    logic fc_arm; logic rx_pend; logic brk;
    sfc_tx_e ts; logic [7:0] tbuf; logic tbf; logic [7:0] tsh; logic [4:0] tn;
    logic [3:0] tones; logic [15:0] tcrc; logic eom; logic abt; logic opened;
    logic txd; logic rtsn; logic tx_pend; logic ext_pend; logic cts_q; logic irq;
  } sfc_st_t;
endpackage

// ---- hw/sfc_channel.sv ----
`timescale 1ns/1ps
// Behaviour
// - Hunt until first flag; rehunt by hunt bit, receiver off or address miss
// - Address search: own or global address
// - Only first character is address-matched
// - Hunt bit aborts reception, awaits flag
// - Zeros deleted, flags never enter queue
// - First-character interrupt, re-armed by command
// - Every-character interrupt; status picks vector
// - Overrun or frame end is special
// - Overrun sticky until error reset
// - Frame end sets CRC and residue valid
// - Length change hits current partial character
// - Receive CRC reset by opening flag
// - Good remainder constant else CRC error
// - CRC bytes delivered as ordinary data
// - Closing flag: special vector, residue code
// - Seven ones: abort status, status interrupt
// - Abort end raises second status interrupt
// - Transmit only with CTS, auto enable set or not
// - Flags start on enable with CTS
// - Preset command loads transmit CRC ones unless CRC select is set
// - Underrun with EOM latch clear sends CRC, then flag and buffer empty, or data at once if the buffer was refilled
// - Command field encodes the channel commands
// - Send abort emits eight ones
// - CRC covers frame, sent inverted
`include "sfc_defs.svh"
module sfc_channel (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire sfc_pkg::sfc_axi_in_t  axi_i,
  output sfc_pkg::sfc_axi_out_t      axi_o,
  input  wire logic                  link_clk,
  input  wire logic                  rx_data,
  input  wire logic                  cts_n,
  output logic                       tx_data,
  output logic                       rts_n,
  output logic                       int_req
);
  import sfc_pkg::*;

  sfc_st_t s;       // Registered state
  sfc_st_t n;       // Next state

  // Reset image shared by arst_n and the channel reset command
  function automatic sfc_st_t st_rst();
    sfc_st_t r;
    r           = '0;
    r.bus.awrdy = 1'b1;
    r.bus.wrdy  = 1'b1;
    r.bus.arrdy = 1'b1;
    r.flag      = `SFC_FLAG_RST;
    r.txd       = 1'b1;
    r.rtsn      = 1'b1;
    // Synchroniser starts at the idle pin level, so no false CTS edge
    r.l_cts     = '1;
    r.eom       = 1'b1;
    r.fc_arm    = 1'b1;
    r.tcrc      = `SFC_CRC_ONES;
    r.crc       = `SFC_CRC_ONES;
    return r;
  endfunction

  // Length code to bit count
  function automatic logic [3:0] bits_of(input logic [1:0] c);
    logic [3:0] v;
    v = `SFC_BITS_C3;
    unique case (c)
      2'h0: v = `SFC_BITS_C0;
      2'h1: v = `SFC_BITS_C1;
      2'h2: v = `SFC_BITS_C2;
      2'h3: v = `SFC_BITS_C3;
    endcase
    return v;
  endfunction

  // One CRC step, shift-left form, first line bit first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
    logic fb;
    fb = c[15] ^ d;
    return {c[14:0], 1'b0} ^ (fb ? `SFC_CRC_POLY : 16'h0000);
  endfunction

  logic       rise;   // Link clock rising edge, receive sample point
  logic       fall;   // Link clock falling edge, transmit launch point
  logic       b;      // Received line bit
  logic       cts;    // Clear-to-send, active high
  logic       fl;     // Flag pattern completes this bit
  logic       stf;    // Bit is an inserted zero
  logic       ob;     // Bit leaving the flag delay line
  logic       go;     // Transmitter allowed to run
  logic       ld;     // Transmitter needs a new unit
  logic       tb;     // Transmit line bit
  logic       chrst;  // Channel reset command seen
  logic       hit;    // Address decodes to a register
  logic       abn;    // Abort level after this bit
  logic [3:0] no;     // Ones run after this bit
  logic [3:0] ln;     // Current receive length
  logic [7:0] an;     // Assembler after this bit
  logic [7:0] chr;    // Completed character
  logic [7:0] wb;     // Write byte
  logic [7:0] ra;     // Read address
  sfc_cmd_t   cm;     // Decoded command byte
  sfc_st0_t   s0;     // Primary status image
  sfc_st1_t   s1;     // Special status image
  logic [2:0] vec;    // Interrupt cause code
  sfc_bus_t   kb;     // Bus state carried over a channel reset

  always_comb begin
    n     = s;
    rise  = 1'b0;
    fall  = 1'b0;
    b     = s.l_rx[1];
    cts   = ~s.l_cts[1];
    fl    = 1'b0;
    stf   = 1'b0;
    ob    = s.dly[0];
    go    = 1'b0;
    ld    = 1'b0;
    tb    = 1'b1;
    chrst = 1'b0;
    hit   = 1'b1;
    abn   = 1'b0;
    no    = 4'h0;
    ln    = bits_of(s.rcr.len);
    an    = s.asm;
    chr   = 8'h00;
    wb    = s.bus.wd;
    ra    = axi_i.araddr;
    cm    = sfc_cmd_t'(s.bus.wd);
    s0    = '0;
    s1    = '0;
    vec   = `SFC_V_NONE;
    kb    = s.bus;

    // Two-flop synchronisers; only the second stage is used below
    n.l_clk  = {s.l_clk[0], link_clk};
    n.l_rx   = {s.l_rx[0], rx_data};
    n.l_cts  = {s.l_cts[0], cts_n};
    n.lclk_q = s.l_clk[1];
    rise     = s.l_clk[1] & ~s.lclk_q;
    fall     = ~s.l_clk[1] & s.lclk_q;

    // Status images, used by the status register reads only
    s0.rca  = s.rca;
    s0.ip   = s.irq;
    s0.tbe  = ~s.tbf;
    s0.hunt = (s.rs == RX_HUNT);
    s0.cts  = cts;
    s0.eom  = s.eom;
    s0.brk  = s.brk;
    s1.sent = (s.ts == TX_MARK);
    s1.res  = s.res;
    s1.ovr  = s.ovr;
    s1.crc_err = s.crcerr;
    s1.eof  = s.eof;
    // Fixed priority; distinct codes only with status affects vector
    if (s.icr.rx_mode != `SFC_RXI_OFF && (s.ovr || s.eof)) begin
      vec = `SFC_V_SPEC;
    end else if (s.rx_pend) begin
      vec = `SFC_V_RX;
    end else if (s.ext_pend) begin
      vec = `SFC_V_EXT;
    end else if (s.tx_pend) begin
      vec = `SFC_V_TX;
    end
    if (!s.icr.sav) begin
      vec = `SFC_V_NONE;
    end

    // Write address and data are taken independently
    if (axi_i.awvalid && s.bus.awrdy) begin
      n.bus.aw_got = 1'b1;
      n.bus.awa    = axi_i.awaddr;
    end
    if (axi_i.wvalid && s.bus.wrdy) begin
      n.bus.w_got = 1'b1;
      n.bus.wd    = axi_i.wdata[7:0];
      n.bus.wst   = axi_i.wstrb[0];
    end
    if (s.bus.bvld && axi_i.bready) begin
      n.bus.bvld = 1'b0;
    end

    // Register write once both halves are held
    if (s.bus.aw_got && s.bus.w_got && !s.bus.bvld) begin
      n.bus.aw_got = 1'b0;
      n.bus.w_got  = 1'b0;
      n.bus.bvld   = 1'b1;
      unique case (s.bus.awa)
        `SFC_A_CMD, `SFC_A_ICR, `SFC_A_RCR, `SFC_A_MODE, `SFC_A_TCR,
        `SFC_A_SADR, `SFC_A_FLAG, `SFC_A_TXD: hit = 1'b1;
        default: hit = 1'b0;
      endcase
      n.bus.bresp = hit ? `SFC_OKAY : `SFC_SLVERR;
      // Only byte lane 0 holds register bits
      if (hit && s.bus.wst) begin
        unique case (s.bus.awa)
          `SFC_A_CMD: begin
            unique case (cm.cmd)
              `SFC_CMD_ABORT:  n.abt = 1'b1;
              `SFC_CMD_RSTEXT: n.ext_pend = 1'b0;
              `SFC_CMD_CHRST:  chrst = 1'b1;
              `SFC_CMD_NEXTRX: n.fc_arm = 1'b1;
              `SFC_CMD_RSTTX:  n.tx_pend = 1'b0;
              `SFC_CMD_ERRRST: begin
                n.ovr    = 1'b0;
                n.eof    = 1'b0;
                n.crcerr = 1'b0;
              end
              default: ;
            endcase
            if (cm.crc == `SFC_CRC_TXPRE && !s.tcr.crc_sel) begin
              n.tcrc = `SFC_CRC_ONES;
            end
            if (cm.crc == `SFC_CRC_EOMCLR) begin
              n.eom = 1'b0;
            end
          end
          `SFC_A_ICR:  n.icr = sfc_icr_t'(wb);
          `SFC_A_RCR: begin
            n.rcr = sfc_rcr_t'(wb);
            if (n.rcr.hunt) begin
              n.rs = RX_HUNT;
              n.dn = 4'h0;
              n.an = 4'h0;
            end
          end
          `SFC_A_MODE: n.mode = wb;
          `SFC_A_TCR:  n.tcr = sfc_tcr_t'(wb);
          `SFC_A_SADR: n.sadr = wb;
          `SFC_A_FLAG: n.flag = wb;
          // Writes to a full buffer are dropped
          default: begin
            if (!s.tbf) begin
              n.tbuf    = wb;
              n.tbf     = 1'b1;
              n.tx_pend = 1'b0;
            end
          end
        endcase
      end
    end

    // Read answers in the cycle after the address is taken
    if (s.bus.rvld && axi_i.rready) begin
      n.bus.rvld = 1'b0;
    end
    if (axi_i.arvalid && s.bus.arrdy) begin
      n.bus.rvld  = 1'b1;
      n.bus.rresp = `SFC_OKAY;
      n.bus.rdata = 8'h00;
      unique case (ra)
        `SFC_A_ICR:  n.bus.rdata = s.icr;
        `SFC_A_RCR:  n.bus.rdata = s.rcr;
        `SFC_A_MODE: n.bus.rdata = s.mode;
        `SFC_A_TCR:  n.bus.rdata = s.tcr;
        `SFC_A_SADR: n.bus.rdata = s.sadr;
        `SFC_A_FLAG: n.bus.rdata = s.flag;
        `SFC_A_ST0:  n.bus.rdata = s0;
        `SFC_A_ST1:  n.bus.rdata = s1;
        `SFC_A_VEC:  n.bus.rdata = {5'h00, vec};
        // Reading data empties the holding register
        `SFC_A_RXD: begin
          n.bus.rdata = s.rbuf;
          n.rca       = 1'b0;
          n.rx_pend   = 1'b0;
        end
        `SFC_A_CMD, `SFC_A_TXD: ;
        default: n.bus.rresp = `SFC_SLVERR;
      endcase
    end

    // Receiver, one bit per link rising edge
    if (!s.rcr.rx_en) begin
      n.rs = RX_HUNT;
      n.dn = 4'h0;
      n.an = 4'h0;
    end else if (rise) begin
      no     = b ? ((s.ones == `SFC_ONES_MAX) ? s.ones : s.ones + 4'h1) : 4'h0;
      n.ones = no;
      n.win  = {b, s.win[7:1]};
      fl     = ({b, s.win[7:1]} == s.flag);
      stf    = ~b && (s.ones == `SFC_STUFF);
      abn    = (no >= `SFC_ABORT_RX);
      n.brk  = abn;
      if (abn != s.brk && s.icr.ext_ie) begin
        n.ext_pend = 1'b1;
      end
      if (fl) begin
        if (s.rs == RX_DATA) begin
          n.eof = 1'b1;
          n.crcerr = (s.crc != `SFC_CRC_GOOD);
          n.res = s.an[2:0];
        end
        if (s.rs != RX_HUNT || s.rs == RX_HUNT) begin
          n.crc = `SFC_CRC_ONES;
        end
        n.rs    = RX_OPEN;
        n.dn    = 4'h0;
        n.an    = 4'h0;
        n.first = 1'b1;
      end else if (abn && (s.rs == RX_OPEN || s.rs == RX_DATA)) begin
        // Aborted frame waits for a flag without hunt status
        n.rs = RX_WAIT;
        n.dn = 4'h0;
        n.an = 4'h0;
      end else if (!stf && (s.rs == RX_OPEN || s.rs == RX_DATA)) begin
        // flag bits held back in delay
        n.dly = {b, s.dly[6:1]};
        if (s.dn != `SFC_DLY) begin
          n.dn = s.dn + 4'h1;
        end else begin
          n.rs = RX_DATA;
          an   = {ob, s.asm[7:1]};
          n.asm = an;
          n.an  = s.an + 4'h1;
          n.crc = crc_step(s.crc, ob);
          if (s.an + 4'h1 >= ln) begin
            chr  = an >> (`SFC_CHAR8 - ln);
            n.an = 4'h0;
            if (s.first && s.rcr.adr_srch && chr != s.sadr && chr != `SFC_GLOBAL) begin
              n.rs = RX_HUNT;
              n.dn = 4'h0;
            end else begin
              n.first = 1'b0;
              // overrun accumulates
              // A read in this very cycle saves the old character
              if (n.rca) begin
                n.ovr = 1'b1;
              end
              n.rbuf = chr;
              n.rca  = 1'b1;
              if (s.fc_arm && s.icr.rx_mode == `SFC_RXI_FIRST) begin
                n.rx_pend = 1'b1;
                n.fc_arm  = 1'b0;
              end
            end
          end
        end
      end
    end
    if (s.icr.rx_mode == `SFC_RXI_EVERY && n.rca) begin
      n.rx_pend = 1'b1;
    end

    // Clear-to-send change is a status event
    n.cts_q = cts;
    if (cts != s.cts_q && s.icr.ext_ie) begin
      n.ext_pend = 1'b1;
    end

    // Transmitter, one bit per link falling edge
    // CTS gates the transmitter, auto enable or not
    go = s.tcr.tx_en && (cts || !s.rcr.auto_en);
    go = go && cts;
    if (fall) begin
      if (s.abt) begin
        n.abt    = 1'b0;
        n.ts     = TX_ABORT;
        n.tn     = `SFC_ABORT_TX;
        n.tsh    = `SFC_GLOBAL;
        // Leading zero caps the ones run whatever went out before
        n.txd    = 1'b0;
        n.opened = 1'b0;
      end else if (s.ts == TX_MARK) begin
        n.txd = 1'b1;
        ld    = go;
      end else if ((s.ts == TX_DATA || s.ts == TX_CRC) && s.tones == `SFC_STUFF) begin
        // Inserted zero, unit not advanced
        n.txd   = 1'b0;
        n.tones = 4'h0;
      end else begin
        tb      = (s.ts == TX_CRC) ? ~s.tcrc[15] : s.tsh[0];
        n.txd   = tb;
        n.tones = (tb && (s.ts == TX_DATA || s.ts == TX_CRC)) ? s.tones + 4'h1 : 4'h0;
        n.tsh   = {1'b1, s.tsh[7:1]};
        n.tn    = s.tn - 5'h01;
        if (s.ts == TX_DATA && s.tcr.crc_en) begin
          n.tcrc = crc_step(s.tcrc, tb);
        end
        if (s.ts == TX_CRC) begin
          n.tcrc = {s.tcrc[14:0], 1'b0};
        end
        ld = (s.tn == 5'h01);
      end
    end
    // Next unit: data, CRC, flag or marking
    if (ld) begin
      n.tsh = s.flag;
      n.tn  = `SFC_FLAG_LEN;
      if (!go) begin
        n.ts = TX_MARK;
      end else if (s.tbf && s.ts != TX_MARK && s.ts != TX_ABORT) begin
        // A frame opens with a flag after mark or abort, but straight after CRC with no flag
        n.ts     = TX_DATA;
        n.tsh    = s.tbuf;
        n.tn     = {1'b0, bits_of(s.tcr.len)};
        n.tbf    = 1'b0;
        n.opened = 1'b1;
        n.tx_pend = s.icr.tx_ie;
      end else if (s.ts == TX_DATA && !s.eom) begin
        // underrun with latch clear sends CRC
        n.ts  = TX_CRC;
        n.tn  = `SFC_CRC_LEN;
        n.eom = 1'b1;
        n.ext_pend = n.ext_pend | s.icr.ext_ie;
      end else if (s.ts == TX_CRC) begin
        n.ts      = TX_FLAG;
        n.opened  = 1'b0;
        n.tx_pend = n.tx_pend | s.icr.tx_ie;
      end else begin
        n.ts     = TX_FLAG;
        n.opened = 1'b0;
      end
    end

    // Channel reset keeps the bus handshake intact
    // The write path has already queued the OKAY answer in n.bus
    if (chrst) begin
      kb    = n.bus;
      n     = st_rst();
      n.bus = kb;
    end

    // Handshake readies follow the held state
    n.bus.awrdy = ~n.bus.aw_got & ~n.bus.bvld;
    n.bus.wrdy  = ~n.bus.w_got & ~n.bus.bvld;
    n.bus.arrdy = ~n.bus.rvld;
    n.rtsn      = ~n.tcr.rts;
    // special only with receive interrupts on
    n.irq = n.ext_pend | n.tx_pend | n.rx_pend |
            ((n.icr.rx_mode != `SFC_RXI_OFF) & (n.ovr | n.eof));
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= st_rst();
    end else begin
      s <= n;
    end
  end

  // Outputs are flop bits
  assign axi_o.awready = s.bus.awrdy;
  assign axi_o.wready  = s.bus.wrdy;
  assign axi_o.bvalid  = s.bus.bvld;
  assign axi_o.bresp   = s.bus.bresp;
  assign axi_o.arready = s.bus.arrdy;
  assign axi_o.rvalid  = s.bus.rvld;
  assign axi_o.rdata   = {24'h000000, s.bus.rdata};
  assign axi_o.rresp   = s.bus.rresp;
  assign tx_data       = s.txd;
  assign rts_n         = s.rtsn;
  assign int_req       = s.irq;
endmodule

// ---- tb/sfc_channel_properties.sv ----
`timescale 1ns/1ps
// Port-level checks on the register slave and the line outputs
module sfc_channel_properties (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire sfc_pkg::sfc_axi_in_t  axi_i,
  input wire sfc_pkg::sfc_axi_out_t axi_o,
  input wire logic                  cts_n,
  input wire logic                  tx_data,
  input wire logic                  rts_n,
  input wire logic                  int_req
);
  import sfc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Both write halves taken at one edge
  sequence wr_take;
    axi_i.awvalid && axi_o.awready && axi_i.wvalid && axi_o.wready;
  endsequence
  // Read address taken
  sequence rd_take;
    axi_i.arvalid && axi_o.arready;
  endsequence
  AST_IDLE_OUT: assert property ($rose(arst_n) |-> tx_data && rts_n && !int_req)
    else $error("line outputs not idle after reset");
  AST_NO_CTS_MARK: assert property (cts_n [*8] |-> tx_data)
    else $error("line left mark without clear to send");
  AST_WR_ANSWER: assert property (wr_take |=> !axi_o.bvalid ##1 axi_o.bvalid)
    else $error("write answer not two edges after take");
  AST_WR_HOLD: assert property (axi_o.bvalid && !axi_i.bready |=> axi_o.bvalid && $stable(axi_o.bresp))
    else $error("write answer dropped early");
  AST_WR_UNMAPPED: assert property (wr_take ##0 (axi_i.awaddr > 8'h2C) |-> ##2 axi_o.bresp == 2'h2)
    else $error("unmapped write not refused");
  AST_RD_ANSWER: assert property (rd_take |=> axi_o.rvalid && !axi_o.arready && axi_o.rdata[31:8] == 24'h0)
    else $error("read answer late or malformed");
  AST_RD_HOLD: assert property (axi_o.rvalid && !axi_i.rready |=> axi_o.rvalid && $stable(axi_o.rdata))
    else $error("read data dropped early");
  AST_RD_UNMAPPED: assert property (rd_take ##0 (axi_i.araddr > 8'h2C) |=> axi_o.rresp == 2'h2)
    else $error("unmapped read not refused");
endmodule
bind sfc_channel sfc_channel_properties u_props (
  .clk(clk),
  .arst_n(arst_n),
  .axi_i(axi_i),
  .axi_o(axi_o),
  .cts_n(cts_n),
  .tx_data(tx_data),
  .rts_n(rts_n),
  .int_req(int_req)
);

// ---- tb/sfc_station.sv ----
`timescale 1ns/1ps
// Remote station; its x1 clock only runs while it has bits to move
module sfc_station (
  output logic     lclk,
  output logic     rxd,
  input wire logic txd
);
  logic [15:0] crc;      // Running check over the frame body
  logic [7:0]  q[$];     // Bytes the channel should hand to the host
  logic        heard[$]; // Line bits taken from the channel
  int          ones;     // Current run of ones sent
  initial begin
    lclk = 1'b0;
    rxd  = 1'b1;
  end
  // One bit period: ours set on the low half, theirs taken at the rise
  task automatic bit_out(input logic b);
    rxd = b;
    #40;
    lclk = 1'b1;
    heard.push_back(txd);
    #40;
    lclk = 1'b0;
  endtask
  task automatic put(input logic b);
    bit_out(b);
    ones = b ? ones + 1 : 0;
    if (ones == 5) begin
      bit_out(1'b0);
      ones = 0;
    end
  endtask
  // Flag goes out unstuffed
  task automatic flag();
    for (int i = 0; i < 8; i++) bit_out(i != 0 && i != 7);
    ones = 0;
  endtask
  // Idle ones; seven or more read as an abort
  task automatic mark(input int n);
    repeat (n) bit_out(1'b1);
  endtask
  // check covers the body, sent inverted
  task automatic frame(input logic [7:0] d[$], input logic bad);
    logic [15:0] c;
    q = d;
    crc = 16'hFFFF;
    flag();
    foreach (d[k]) for (int i = 0; i < 8; i++) begin
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[k][i]) ? 16'h1021 : 16'h0000);
      put(d[k][i]);
    end
    c = ~crc ^ {15'h0000, bad};
    c = {<<{c}};
    for (int i = 0; i < 16; i++) put(c[i]);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    flag();
    // Spare flag gives the last byte time to land
    flag();
    rxd = 1'b1;
  endtask
endmodule

// ---- tb/tb_sfc_channel.sv ----
`timescale 1ns/1ps
`include "sfc_defs.svh"
module tb_sfc_channel;
  import sfc_pkg::*;
  logic         clk;
  logic         arst_n;
  logic         cts_n;
  logic         lclk;
  logic         rxd;
  logic         txd;
  logic         rts_n;
  logic         int_req;
  sfc_axi_in_t  ai;
  sfc_axi_out_t ao;
  sfc_axi_out_t s;       // Slave outputs as they stand before an edge
  logic [7:0]   rv;      // Last byte read
  logic [1:0]   rsp;     // Last response code
  logic [7:0]   got[$];  // Bytes drained from the channel
  logic [7:0]   exp_q[$];// Bytes the host should see
  logic [7:0]   sadr;    // Our station address
  logic         busy;    // Station still sending
  logic         fl;      // Flag seen on the line
  int           run;     // Longest run of ones on the line
  int           failures;
  int           comparisons;
  sfc_channel DUT (.clk(clk), .arst_n(arst_n), .axi_i(ai), .axi_o(ao), .link_clk(lclk),
    .rx_data(rxd), .cts_n(cts_n), .tx_data(txd), .rts_n(rts_n), .int_req(int_req));
  sfc_station st (.lclk(lclk), .rxd(rxd), .txd(txd));
  always #2 clk = ~clk;
  // Snapshot on the low half so the edge never races the flops
  task automatic step();
    @(negedge clk);
    s = ao;
    @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  // Write; response ready raised late so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ai.awvalid <= 1'b1;
    ai.awaddr  <= a;
    ai.wvalid  <= 1'b1;
    ai.wdata   <= {24'h0, d};
    do begin
      step();
      if (s.awready) ai.awvalid <= 1'b0;
      if (s.wready) ai.wvalid <= 1'b0;
    end while (!s.bvalid);
    ai.bready <= 1'b1;
    step();
    ai.bready <= 1'b0;
    rsp = s.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    ai.arvalid <= 1'b1;
    ai.araddr  <= a;
    do begin
      step();
      if (s.arready) ai.arvalid <= 1'b0;
    end while (!s.rvalid);
    ai.rready <= 1'b1;
    step();
    ai.rready <= 1'b0;
    rv = s.rdata[7:0];
    rsp = s.rresp;
  endtask
  // Longest ones run and any flag in what the station heard
  task automatic scan();
    int c;
    logic [7:0] w;
    c = 0;
    run = 0;
    fl = 1'b0;
    w = 8'h00;
    foreach (st.heard[i]) begin
      w = {st.heard[i], w[7:1]};
      c = st.heard[i] ? c + 1 : 0;
      if (c > run) run = c;
      if (w == 8'h7E) fl = 1'b1;
    end
    st.heard.delete();
  endtask
  // Cases: own address, global with bad check, foreign, own left unread
  task automatic frame_case(input int k);
    logic [7:0] f[$];
    logic       acc;
    acc = (k != 2);
    f = {(k == 1) ? 8'hFF : (k == 2) ? 8'h3C : sadr, 8'h13, 8'($urandom()), 8'($urandom())};
    wr(`SFC_A_RCR, 8'hD5);
    rd(`SFC_A_ST0);
    chk(rv & 8'h10, 8'h10);
    got.delete();
    busy = 1'b1;
    fork
      begin
        st.frame(f, k == 1);
        busy = 1'b0;
      end
      while (busy && k != 3) begin
        rd(`SFC_A_ST0);
        if (rv[0]) begin
          rd(`SFC_A_RXD);
          got.push_back(rv);
        end
      end
    join
    exp_q = st.q;
    if (!acc) exp_q.delete();
    if (k != 3) chk(8'(got.size()), 8'(exp_q.size()));
    if (k != 3 && got.size() == exp_q.size())
      foreach (got[i]) chk(got[i], exp_q[i]);
    rd(`SFC_A_ST1);
    if (acc) chk(rv & 8'hEE, {1'b1, k == 1, k == 3, 5'h00});
    rd(`SFC_A_VEC);
    if (acc) chk({int_req, rv[6:0]}, 8'h84);
    rd(`SFC_A_RXD);
    rd(`SFC_A_ST1);
    if (k == 3) chk(rv & 8'h20, 8'h20);
    wr(`SFC_A_CMD, 8'h30);
    rd(`SFC_A_ST1);
    chk(rv & 8'hE0, 8'h00);
    chk({7'h00, int_req}, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    cts_n = 1'b1;
    ai = '0;
    ai.wstrb = 4'hF;
    failures = 0;
    comparisons = 0;
    void'($urandom(50970));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(`SFC_A_FLAG);
    chk(rv, 8'h7E);
    rd(8'h40);
    chk({6'h00, rsp}, {6'h00, `SFC_SLVERR});
    wr(8'h40, 8'h00);
    chk({6'h00, rsp}, {6'h00, `SFC_SLVERR});
    wr(`SFC_A_MODE, 8'h20);
    wr(`SFC_A_ICR, 8'h0C);
    sadr = 8'h40 | 8'($urandom() & 32'h1F);
    wr(`SFC_A_SADR, sadr);
    for (int k = 0; k < 4; k++) frame_case(k);
    st.mark(8);
    rd(`SFC_A_ST0);
    chk(rv & 8'h80, 8'h80);
    // Transmitter enabled but clear to send still off
    wr(`SFC_A_TCR, 8'h6B);
    chk({7'h00, rts_n}, 8'h00);
    st.mark(16);
    scan();
    chk({7'h00, fl}, 8'h00);
    cts_n <= 1'b0;
    st.mark(24);
    scan();
    // Abort lands mid-flag; one scan spans the flags before it
    st.mark(24);
    wr(`SFC_A_CMD, 8'h08);
    st.mark(24);
    scan();
    chk({7'h00, fl}, 8'h01);
    chk({7'h00, run >= 8 && run <= 13}, 8'h01);
    wr(`SFC_A_CMD, 8'h18);
    rd(`SFC_A_ST0);
    chk(rv, 8'h74);
    tally_and_finish();
  end
endmodule
